// ===== hw/sep_trap_defs.vh
`ifndef SEP_TRAP_DEFS_VH
`define SEP_TRAP_DEFS_VH

// data path widths
`define SEP_XW            32
`define SEP_CODE_W        5

// register offsets on the plain register port
`define SEP_OFF_EPC       4'h0
`define SEP_OFF_CAUSE     4'h4
`define SEP_OFF_TVAL      4'h8
`define SEP_OFF_STATUS    4'hC

// reset values
`define SEP_EPC_RST       32'h00000000
`define SEP_CAUSE_RST     32'h00000000
`define SEP_TVAL_RST      32'h00000000
`define SEP_COUNT_RST     32'h00000000
`define SEP_CODE_RST      5'h00
`define SEP_RDATA_RST     32'h00000000

// field positions
`define SEP_CAUSE_IRQ_BIT 31
`define SEP_EPC_LSB_MASK  32'hFFFFFFFE

// exception codes
`define SEP_EC_IMISAL     5'h00
`define SEP_EC_IACCESS    5'h01
`define SEP_EC_ILLEGAL    5'h02
`define SEP_EC_BREAK      5'h03
`define SEP_EC_LMISAL     5'h04
`define SEP_EC_LACCESS    5'h05
`define SEP_EC_SMISAL     5'h06
`define SEP_EC_SACCESS    5'h07
`define SEP_EC_ECALL_U    5'h08
`define SEP_EC_IPAGE      5'h0C
`define SEP_EC_LPAGE      5'h0D
`define SEP_EC_SPAGE      5'h0F
`define SEP_EC_SWCHECK    5'h12
`define SEP_EC_HWERR      5'h13

// implementation choices
`define SEP_TVAL_INFO     1'b1
`define SEP_MISAL_HIGH    1'b0
`define SEP_TVAL_INSTBITS 1'b1
`define SEP_SHORT_MASK    32'h0000FFFF

`endif

// ===== hw/sep_trap_unit.v
// Summary of operation
// RL1: report only the top exception; instruction breakpoint first, fetch translation next
// RL2: then fetch physical fault, illegal, misaligned target, ecall, ebreak, data break
// RL3: then data translation fault, data physical fault, misaligned data last
// RL4: misaligned data may rank above data faults, fixed at build time
// RL5: misaligned target comes from control flow, ranked below fetch faults
// RL6: instruction breakpoint shares code 3 but ranks above ebreak and watchpoint
// RL7: software check writes zero or the extension's value, at its rank
// RL8: hardware error reports instruction pc and zero or failing address
// RL9: trap value written only on trap entry, software writes still land
// RL10: trap value read-only zero when no exception supplies nonzero value
// RL11: address-type exceptions report the faulting virtual address
// RL12: with paging on, physical access faults still report virtual address
// RL13: misaligned data faults report the address of the faulting portion
// RL14: fetch faults report faulting portion; exception pc stays instruction start
// RL15: illegal instruction bits right-justified, unused upper bits cleared
// RL16: full instruction bits arrive with the request and are captured
// RL17: every other trap writes zero into the trap value
// RL18: trap value accepts any value and holds all addresses and zero
// RL19: cause written on trap: top bit interrupt, low field the code
// RL20: exception pc written with the trapping instruction address
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sep_trap_defs.vh"

module sep_trap_unit
(
  mclk,
  rst_n,
  exc_valid,
  exc_pc,
  priv_mode,
  irq_valid,
  irq_code,
  ibrk_hit,
  ixl_fault,
  ixl_page,
  ixl_addr,
  iphys_fault,
  ihw_err,
  iphys_addr,
  ill_inst,
  inst_bits,
  inst_short,
  imis_fault,
  imis_target,
  ecall,
  ebreak,
  swc_fault,
  swc_tval,
  dbrk_hit,
  d_store,
  d_addr,
  dxl_fault,
  dxl_page,
  dfault_addr,
  dphys_fault,
  dhw_err,
  dmis_fault,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  trap_taken,
  trap_code
);
  input  wire        mclk;
  input  wire        rst_n;
  input  wire        exc_valid;
  input  wire [31:0] exc_pc;
  input  wire [1:0]  priv_mode;
  input  wire        irq_valid;
  input  wire [4:0]  irq_code;
  input  wire        ibrk_hit;
  input  wire        ixl_fault;
  input  wire        ixl_page;
  input  wire [31:0] ixl_addr;
  input  wire        iphys_fault;
  input  wire        ihw_err;
  input  wire [31:0] iphys_addr;
  input  wire        ill_inst;
  input  wire [31:0] inst_bits;
  input  wire        inst_short;
  input  wire        imis_fault;
  input  wire [31:0] imis_target;
  input  wire        ecall;
  input  wire        ebreak;
  input  wire        swc_fault;
  input  wire [31:0] swc_tval;
  input  wire        dbrk_hit;
  input  wire        d_store;
  input  wire [31:0] d_addr;
  input  wire        dxl_fault;
  input  wire        dxl_page;
  input  wire [31:0] dfault_addr;
  input  wire        dphys_fault;
  input  wire        dhw_err;
  input  wire        dmis_fault;
  input  wire [3:0]  reg_addr;
  input  wire [31:0] reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [31:0] reg_rdata;
  output reg         trap_taken;
  output reg  [4:0]  trap_code;

  reg        rst_meta_reg;
  reg        rst_sync_reg;
  reg [31:0] epc_reg;
  reg [31:0] cause_reg;
  reg [31:0] tval_reg;
  reg [31:0] trap_count_reg;
  reg        exc_hit;
  reg [4:0]  exc_code;
  reg [31:0] exc_tval;
  reg [31:0] epc_next;
  reg [31:0] cause_next;
  reg [31:0] tval_next;
  reg [31:0] rdata_next;
  wire       take;

  // pick load or store flavour of a data-side code
  function [4:0] sel_ls;
    input       store;
    input [4:0] load_code;
    input [4:0] store_code;
    begin
      sel_ls = store ? store_code : load_code;
    end
  endfunction

  // legalise a trap value for the trap value register
  function [31:0] legal_tval;
    input [31:0] value;
    begin
      legal_tval = `SEP_TVAL_INFO ? value : `SEP_TVAL_RST; // RL10 RL18
    end
  endfunction

  // clear the low bit of an exception pc
  function [31:0] align_pc;
    input [31:0] addr;
    begin
      align_pc = addr & `SEP_EPC_LSB_MASK;        // RL20
    end
  endfunction

  // pack interrupt flag and code into the cause word
  function [31:0] pack_cause;
    input       irq;
    input [4:0] code;
    begin
      pack_cause = {irq, 26'h0, code};            // RL19
    end
  endfunction

  // reset release through two flops
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // fixed-priority choice among the exceptions of one instruction
  always @*
  begin
    exc_hit  = 1'b1;
    exc_code = `SEP_EC_BREAK;
    exc_tval = `SEP_TVAL_RST;
    if (ibrk_hit)
    begin
      exc_code = `SEP_EC_BREAK;                   // RL1 RL6
      exc_tval = exc_pc;                          // RL11
    end
    else if (ixl_fault)
    begin
      exc_code = ixl_page ? `SEP_EC_IPAGE : `SEP_EC_IACCESS; // RL1
      exc_tval = ixl_addr;                        // RL14
    end
    else if (ihw_err)
    begin
      exc_code = `SEP_EC_HWERR;                   // RL8
      exc_tval = iphys_addr;                      // RL8
    end
    else if (iphys_fault)
    begin
      exc_code = `SEP_EC_IACCESS;                 // RL2
      exc_tval = iphys_addr;                      // RL12 RL14
    end
    else if (ill_inst)
    begin
      exc_code = `SEP_EC_ILLEGAL;                 // RL2
      if (`SEP_TVAL_INSTBITS)
        exc_tval = inst_short ? (inst_bits & `SEP_SHORT_MASK)
                              : inst_bits;        // RL15 RL16
    end
    else if (imis_fault)
    begin
      exc_code = `SEP_EC_IMISAL;                  // RL2 RL5
      exc_tval = imis_target;                     // RL11
    end
    else if (ecall)
      exc_code = `SEP_EC_ECALL_U + {3'h0, priv_mode}; // RL2 RL17
    else if (ebreak)
    begin
      exc_code = `SEP_EC_BREAK;                   // RL2 RL6
      exc_tval = exc_pc;
    end
    else if (swc_fault)
    begin
      exc_code = `SEP_EC_SWCHECK;                 // RL7
      exc_tval = swc_tval;                        // RL7
    end
    else if (dbrk_hit)
    begin
      exc_code = `SEP_EC_BREAK;                   // RL2 RL6
      exc_tval = d_addr;                          // RL11
    end
    else if (dmis_fault && `SEP_MISAL_HIGH)
    begin
      exc_code = sel_ls(d_store, `SEP_EC_LMISAL, `SEP_EC_SMISAL); // RL4
      exc_tval = d_addr;                          // RL11
    end
    else if (dxl_fault)
    begin
      exc_code = dxl_page
        ? sel_ls(d_store, `SEP_EC_LPAGE, `SEP_EC_SPAGE)
        : sel_ls(d_store, `SEP_EC_LACCESS, `SEP_EC_SACCESS); // RL3
      exc_tval = dfault_addr;                     // RL13
    end
    else if (dhw_err)
    begin
      exc_code = `SEP_EC_HWERR;                   // RL8
      exc_tval = dfault_addr;
    end
    else if (dphys_fault)
    begin
      exc_code = sel_ls(d_store, `SEP_EC_LACCESS, `SEP_EC_SACCESS); // RL3
      exc_tval = dfault_addr;                     // RL12 RL13
    end
    else if (dmis_fault)
    begin
      exc_code = sel_ls(d_store, `SEP_EC_LMISAL, `SEP_EC_SMISAL); // RL3 RL4
      exc_tval = d_addr;                          // RL11
    end
    else
      exc_hit = 1'b0;
  end

  // a trap is taken for an interrupt or a raised exception
  assign take = irq_valid || (exc_valid && exc_hit);

  // next values: trap entry first, then software writes
  always @*
  begin
    epc_next   = epc_reg;
    cause_next = cause_reg;
    tval_next  = tval_reg;
    if (take)
    begin
      epc_next   = align_pc(exc_pc);              // RL20 RL14
      if (irq_valid)
      begin
        cause_next = pack_cause(1'b1, irq_code);  // RL19
        tval_next  = `SEP_TVAL_RST;               // RL17
      end
      else
      begin
        cause_next = pack_cause(1'b0, exc_code);  // RL19
        tval_next  = legal_tval(exc_tval);        // RL9
      end
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SEP_OFF_EPC:   epc_next   = align_pc(reg_wdata);
        `SEP_OFF_CAUSE: cause_next = pack_cause(reg_wdata[31], reg_wdata[4:0]);
        `SEP_OFF_TVAL:  tval_next  = legal_tval(reg_wdata); // RL9 RL18
        default:        tval_next  = tval_reg;
      endcase
    end
  end

  // read mux
  always @*
  begin
    case (reg_addr)
      `SEP_OFF_EPC:    rdata_next = epc_reg;
      `SEP_OFF_CAUSE:  rdata_next = cause_reg;
      `SEP_OFF_TVAL:   rdata_next = tval_reg;
      `SEP_OFF_STATUS: rdata_next = trap_count_reg;
      default:         rdata_next = 32'h00000000;
    endcase
  end

  // trap state registers
  always @(posedge mclk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      epc_reg   <= `SEP_EPC_RST;
      cause_reg <= `SEP_CAUSE_RST;
      tval_reg  <= `SEP_TVAL_RST;
    end
    else
    begin
      epc_reg   <= epc_next;
      cause_reg <= cause_next;
      tval_reg  <= tval_next;                     // RL9
    end
  end

  // trap pulse, last code and trap counter
  always @(posedge mclk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      trap_count_reg <= `SEP_COUNT_RST;
      trap_taken     <= 1'b0;
      trap_code      <= `SEP_CODE_RST;
    end
    else
    begin
      trap_taken <= take;
      if (take)
      begin
        trap_code      <= cause_next[4:0];
        trap_count_reg <= trap_count_reg + 32'h00000001;
      end
    end
  end

  // read data stands only in the cycle after a read strobe
  always @(posedge mclk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      reg_rdata <= `SEP_RDATA_RST;
    else
      reg_rdata <= reg_rd ? rdata_next : `SEP_RDATA_RST;
  end

endmodule

// ===== verif/sep_trap_sva.sv
`timescale 1ns/1ps
`include "sep_trap_defs.vh"
module sep_trap_sva
(
  input wire        mclk,
  input wire        rst_n,
  input wire        exc_valid,
  input wire [31:0] exc_pc,
  input wire        irq_valid,
  input wire [4:0]  irq_code,
  input wire        ibrk_hit,
  input wire        ixl_fault,
  input wire        ixl_page,
  input wire [3:0]  reg_addr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        trap_taken,
  input wire [4:0]  trap_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // trap selection and reporting
  irq_wins_a: assert property (
    irq_valid |=> trap_taken && trap_code == $past(irq_code))
    else $error("interrupt not reported");
  ibrk_first_a: assert property (
    exc_valid && ibrk_hit && !irq_valid |=> trap_taken && trap_code == 5'h03)
    else $error("breakpoint not first");
  ixl_second_a: assert property (
    exc_valid && ixl_fault && !ibrk_hit && !irq_valid |=>
    trap_code == ($past(ixl_page) ? 5'h0C : 5'h01))
    else $error("fetch fault code wrong");
  idle_quiet_a: assert property (
    !exc_valid && !irq_valid |=> !trap_taken)
    else $error("trap without request");
  code_hold_a: assert property (
    !trap_taken |-> $stable(trap_code))
    else $error("code moved without trap");
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data without read");
  cause_read_a: assert property (
    $fell(trap_taken) && reg_rd && reg_addr == 4'h4 |=>
    reg_rdata[4:0] == $past(trap_code))
    else $error("cause differs from code");
  epc_read_a: assert property (
    exc_valid && ibrk_hit && !irq_valid ##4 reg_rd && reg_addr == 4'h0 |=>
    reg_rdata == ($past(exc_pc, 5) & 32'hFFFFFFFE))
    else $error("exception pc wrong");
endmodule

bind sep_trap_unit sep_trap_sva sep_trap_sva_inst (.mclk(mclk),
  .rst_n(rst_n), .exc_valid(exc_valid), .exc_pc(exc_pc),
  .irq_valid(irq_valid), .irq_code(irq_code), .ibrk_hit(ibrk_hit),
  .ixl_fault(ixl_fault), .ixl_page(ixl_page), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trap_taken(trap_taken),
  .trap_code(trap_code));

// ===== verif/sep_pipe_model.sv
`timescale 1ns/1ps
module sep_pipe_model
(
  input  wire        fire,
  input  wire [13:0] sel,
  input  wire [31:0] va,
  output wire        exc_valid,
  output wire [13:0] flags,
  output wire [31:0] pc
);
  // flags only while offered; idle address shows inverse, not last value
  assign exc_valid = fire;
  assign flags     = fire ? sel : 14'h0000;
  assign pc        = fire ? va : ~va;
endmodule

// ===== verif/sep_trap_unit_tb_top.sv
`timescale 1ns/1ps
module sep_trap_unit_tb_top;
  reg         mclk;
  reg         rst_n;
  reg         fire;
  reg  [13:0] sel;
  reg  [31:0] va;
  reg         pg;
  reg         irq_valid;
  reg         sm;
  reg  [3:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg  [4:0]  ec;
  reg  [31:0] et;
  wire        exc_valid;
  wire [13:0] fl;
  wire [31:0] ad;
  wire [31:0] reg_rdata;
  wire        trap_taken;
  wire [4:0]  trap_code;
  integer     fail_count;
  integer     check_count;
  integer     j;
  integer     p;

  sep_pipe_model sep_pipe_model_inst (.fire(fire), .sel(sel), .va(va),
    .exc_valid(exc_valid), .flags(fl), .pc(ad));
  sep_trap_unit sep_trap_unit_inst (.mclk(mclk), .rst_n(rst_n),
    .exc_valid(exc_valid), .exc_pc(ad),
    .priv_mode(sm ? 2'h1 : (pg ? 2'h3 : 2'h0)),
    .irq_valid(irq_valid), .irq_code(5'h0B), .ibrk_hit(fl[13]),
    .ixl_fault(fl[12]), .ixl_page(pg), .ixl_addr(ad + 32'h10),
    .ihw_err(fl[11]), .iphys_fault(fl[10]), .iphys_addr(ad + 32'h20),
    .ill_inst(fl[9]), .inst_bits(ad ^ 32'h5A5A5A5A), .inst_short(!pg),
    .imis_fault(fl[8]), .imis_target(ad + 32'h30), .ecall(fl[7]),
    .ebreak(fl[6]), .swc_fault(fl[5]), .swc_tval(ad + 32'h40),
    .dbrk_hit(fl[4]), .d_store(pg), .d_addr(ad + 32'h50),
    .dxl_fault(fl[3]), .dxl_page(pg), .dfault_addr(ad + 32'h60),
    .dhw_err(fl[2]), .dphys_fault(fl[1]), .dmis_fault(fl[0]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trap_taken(trap_taken),
    .trap_code(trap_code));

  // free-running hart clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task conclude;
  begin
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  task chk(input [63:0] n, input [31:0] e, input [31:0] g);
  begin
    check_count = check_count + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  end
  endtask

  task wr(input [3:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  end
  endtask

  task rd(input [3:0] a, input [63:0] n, input [31:0] e);
  begin
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  end
  endtask

  // offer one instruction's flags and wait for the trap pulse
  task trap(input [13:0] s, input q);
    integer k;
  begin
    @(posedge mclk);
    fire <= 1'b1;
    sel <= s;
    irq_valid <= q;
    @(posedge mclk);
    fire <= 1'b0;
    irq_valid <= 1'b0;
    #1 k = 0;
    while (trap_taken !== 1'b1)
    begin
      k = k + 1;
      if (k > 8)
      begin
        fail_count = fail_count + 1;
        conclude;
      end
      @(posedge mclk);
      #1;
    end
  end
  endtask

  // expected code and trap value of the j-th cause in priority order
  task expect_of(input integer i);
  begin
    case (i)
      0: {ec, et} = {5'h03, va};
      1: {ec, et} = {pg ? 5'h0C : 5'h01, va + 32'h10};
      2: {ec, et} = {5'h13, va + 32'h20};
      3: {ec, et} = {5'h01, va + 32'h20};
      4: {ec, et} = {5'h02, (va ^ 32'h5A5A5A5A) &
                     (pg ? 32'hFFFFFFFF : 32'h0000FFFF)};
      5: {ec, et} = {5'h00, va + 32'h30};
      6: {ec, et} = {pg ? 5'h0B : 5'h08, 32'h0};
      7: {ec, et} = {5'h03, va};
      8: {ec, et} = {5'h12, va + 32'h40};
      9: {ec, et} = {5'h03, va + 32'h50};
      10: {ec, et} = {pg ? 5'h0F : 5'h05, va + 32'h60};
      11: {ec, et} = {5'h13, va + 32'h60};
      12: {ec, et} = {pg ? 5'h07 : 5'h05, va + 32'h60};
      default: {ec, et} = {pg ? 5'h06 : 5'h04, va + 32'h50};
    endcase
  end
  endtask

  // main sequence
  initial
  begin
    fail_count = 0;
    check_count = 0;
    {rst_n, fire, sel, va, pg, irq_valid, sm} = 0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(4'h8, "tval", 32'h0);
    rd(4'hC, "count", 32'h0);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, "count", 32'h0);
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0, "epc", 32'hFFFFFFFE);
    wr(4'h4, 32'hFFFFFFFF);
    rd(4'h4, "cause", 32'h8000001F);
    wr(4'h8, 32'hFFFFFFFF);
    rd(4'h8, "tval", 32'hFFFFFFFF);
    rd(4'h2, "unmap", 32'h0);
    for (p = 1; p >= 0; p = p - 1)
      for (j = 0; j < 14; j = j + 1)
      begin
        @(posedge mclk);
        pg <= p;
        va <= 32'h40000101 + (j << 8);
        trap(14'h3FFF >> j, 1'b0);
        expect_of(j);
        chk("code", {27'h0, ec}, {27'h0, trap_code});
        rd(4'h4, "cause", {27'h0, ec});
        rd(4'h0, "epc", va & 32'hFFFFFFFE);
        rd(4'h8, "tval", et);
      end
    @(posedge mclk);
    fire <= 1'b1;
    sel <= 14'h0000;
    @(posedge mclk);
    fire <= 1'b0;
    #1 chk("taken", 32'h0, {31'h0, trap_taken});
    rd(4'h8, "tval", et);
    rd(4'hC, "count", 32'h0000001C);
    // supervisor ecall with a software write in the same cycle
    sm <= 1'b1;
    @(posedge mclk);
    fire <= 1'b1;
    sel <= 14'h0080;
    reg_wr <= 1'b1;
    reg_addr <= 4'h8;
    reg_wdata <= 32'hFFFFFFFF;
    @(posedge mclk);
    fire <= 1'b0;
    reg_wr <= 1'b0;
    sm <= 1'b0;
    #1 chk("taken", 32'h1, {31'h0, trap_taken});
    chk("code", 32'h9, {27'h0, trap_code});
    rd(4'h8, "tval", 32'h0);
    trap(14'h2000, 1'b1);
    rd(4'h4, "cause", 32'h8000000B);
    rd(4'h8, "tval", 32'h0);
    rd(4'hC, "count", 32'h0000001E);
    conclude;
  end
endmodule
